// File: hdl/frtc_consts.svh
`ifndef FRTC_CONSTS_SVH
`define FRTC_CONSTS_SVH

// clock and time base
`define FRTC_CLK_PERIOD_NS 10
`define FRTC_US_NS 1000
`define FRTC_US_CYCLES (`FRTC_US_NS / `FRTC_CLK_PERIOD_NS)
`define FRTC_PRE_LAST (`FRTC_US_CYCLES - 1)

// periodic tick, counted in timer microseconds
`define FRTC_MS_TICK_NS 1024000
`define FRTC_MS_TICK_US (`FRTC_MS_TICK_NS / `FRTC_US_NS)
`define FRTC_MS_TICK_MASK (`FRTC_MS_TICK_US - 1)

// timer and capture geometry
`define FRTC_TIMER_W 16
`define FRTC_CAP_W 8
`define FRTC_SLICE_MAX 8
`define FRTC_TIMER_RST 16'h0000
`define FRTC_TIMER_MAX 16'hffff
`define FRTC_CAP_RST 8'h00

`endif

// File: hdl/frtc_pkg.sv
package frtc_pkg;

    // one capture channel: rising and falling edge times
    typedef struct packed {
        logic [7:0] rise;
        logic [7:0] fall;
    } frtc_cap_s;

    // capture configuration, per channel where indexed
    typedef struct packed {
        logic [1:0] rise_en;
        logic [1:0] fall_en;
        logic gang;
        logic [1:0][3:0] slice_lsb;
    } frtc_cfg_s;

endpackage

// File: hdl/frtc_timer_capture.sv
`timescale 1ns/1ps
`include "frtc_consts.svh"
module frtc_timer_capture
    import frtc_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic rst,
    // capture pins
    input wire logic capture_input_a,
    input wire logic capture_input_b,
    // configuration
    input wire frtc_cfg_s cap_cfg,
    input wire logic intv_en,
    input wire logic [15:0] intv_period,
    // timer and captures
    output logic [15:0] timer_count,
    output frtc_cap_s [1:0] cap_val,
    // interrupt pulses
    output logic intv_irq,
    output logic ms_tick_irq,
    output logic wrap_irq,
    output logic [1:0] cap_irq
);

    logic [6:0] pre_reg;
    logic us_tick;
    logic [15:0] timer_reg;
    logic [15:0] intv_cnt_reg;
    logic [1:0] pins;
    logic [1:0][2:0] sync_reg;
    logic [1:0] lvl_reg;
    logic [1:0] rise_ev;
    logic [1:0] fall_ev;
    logic [1:0][7:0] slice;
    logic [1:0] st_rise;
    logic [1:0] st_fall;

    assign pins = {capture_input_b, capture_input_a};

    // microsecond prescaler off the system clock
    assign us_tick = (pre_reg == 7'(`FRTC_PRE_LAST));

    always_ff @(posedge mclk) begin
        if (rst) begin
            pre_reg <= 7'h00;
        end else if (us_tick) begin
            pre_reg <= 7'h00;
        end else begin
            pre_reg <= pre_reg + 7'h01;
        end
    end

    // timer never stops, so two reads give elapsed time
    always_ff @(posedge mclk) begin
        if (rst) begin
            timer_reg <= `FRTC_TIMER_RST;
        end else if (us_tick) begin
            timer_reg <= timer_reg + 16'h0001;
        end
    end

    assign timer_count = timer_reg;

    always_ff @(posedge mclk) begin
        if (rst) begin
            wrap_irq <= 1'b0;
        end else begin
            // pulse in the cycle the count reads zero
            wrap_irq <= us_tick && (timer_reg == `FRTC_TIMER_MAX);
        end
    end

    always_ff @(posedge mclk) begin
        if (rst) begin
            ms_tick_irq <= 1'b0;
        end else begin
            ms_tick_irq <= us_tick && ((timer_reg & 16'(`FRTC_MS_TICK_MASK))
                == 16'(`FRTC_MS_TICK_MASK));
        end
    end

    // interval: fires every intv_period us; zero acts as one
    always_ff @(posedge mclk) begin
        if (rst) begin
            intv_cnt_reg <= 16'h0000;
            intv_irq <= 1'b0;
        end else if (!intv_en) begin
            intv_cnt_reg <= intv_period;
            intv_irq <= 1'b0;
        end else if (us_tick && intv_cnt_reg <= 16'h0001) begin
            intv_cnt_reg <= intv_period;
            intv_irq <= 1'b1;
        end else begin
            if (us_tick) begin
                intv_cnt_reg <= intv_cnt_reg - 16'h0001;
            end
            intv_irq <= 1'b0;
        end
    end

    genvar i;
    generate
        for (i = 0; i < 2; i++) begin : g_ch
            // three stages; level moves only when stages two and three agree
            always_ff @(posedge mclk) begin
                if (rst) begin
                    sync_reg[i] <= 3'h0;
                end else begin
                    sync_reg[i] <= {sync_reg[i][1:0], pins[i]};
                end
            end

            assign rise_ev[i] = (sync_reg[i][1] == sync_reg[i][2])
                && sync_reg[i][2] && !lvl_reg[i];
            assign fall_ev[i] = (sync_reg[i][1] == sync_reg[i][2])
                && !sync_reg[i][2] && lvl_reg[i];

            always_ff @(posedge mclk) begin
                if (rst) begin
                    lvl_reg[i] <= 1'b0;
                end else if (rise_ev[i] || fall_ev[i]) begin
                    lvl_reg[i] <= sync_reg[i][2];
                end
            end

            // slice offsets past the top clamp, keeping 8 real bits
            assign slice[i] = (cap_cfg.slice_lsb[i] >= 4'(`FRTC_SLICE_MAX))
                ? timer_reg[15:8]
                : 8'(timer_reg >> cap_cfg.slice_lsb[i]);

            // ganged: pin a drives both, channel 1 holds the high byte
            assign st_rise[i] = cap_cfg.gang
                ? (rise_ev[0] && cap_cfg.rise_en[0])
                : (rise_ev[i] && cap_cfg.rise_en[i]);
            assign st_fall[i] = cap_cfg.gang
                ? (fall_ev[0] && cap_cfg.fall_en[0])
                : (fall_ev[i] && cap_cfg.fall_en[i]);

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cap_val[i].rise <= `FRTC_CAP_RST;
                end else if (st_rise[i]) begin
                    cap_val[i].rise <= cap_cfg.gang
                        ? timer_reg[8*i +: 8] : slice[i];
                end
            end

            always_ff @(posedge mclk) begin
                if (rst) begin
                    cap_val[i].fall <= `FRTC_CAP_RST;
                end else if (st_fall[i]) begin
                    cap_val[i].fall <= cap_cfg.gang
                        ? timer_reg[8*i +: 8] : slice[i];
                end
            end

            // one source per channel; ganged pair reports on channel 0
            always_ff @(posedge mclk) begin
                if (rst) begin
                    cap_irq[i] <= 1'b0;
                end else begin
                    cap_irq[i] <= (st_rise[i] || st_fall[i])
                        && !(cap_cfg.gang && i == 1);
                end
            end
        end
    endgenerate

    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);

    sequence s_store_rise_a;
        rise_ev[0] && cap_cfg.rise_en[0] && !cap_cfg.gang;
    endsequence

    sequence s_gang_rise;
        rise_ev[0] && cap_cfg.rise_en[0] && cap_cfg.gang;
    endsequence

    chk_tick_spacing: assert property (
        us_tick |=> !us_tick [*8])
        else $error("microsecond ticks too close");

    chk_timer_inc: assert property (
        us_tick |=> timer_reg == $past(timer_reg) + 16'h0001)
        else $error("timer did not advance on tick");

    chk_timer_hold: assert property (
        !us_tick |=> $stable(timer_reg))
        else $error("timer moved between ticks");

    chk_wrap_cause: assert property (
        us_tick && timer_reg == 16'hffff |=> wrap_irq && timer_reg == 16'h0)
        else $error("wrap not flagged at rollover");

    chk_wrap_only: assert property (
        wrap_irq |-> timer_reg == 16'h0 && $past(us_tick))
        else $error("spurious wrap interrupt");

    chk_ms_tick: assert property (
        ms_tick_irq |-> timer_reg[9:0] == 10'h000 && $past(us_tick))
        else $error("tick interrupt off the 1024 us grid");

    chk_intv_irq: assert property (
        intv_irq |-> $past(intv_en) && $past(us_tick))
        else $error("interval fired while disabled");

    chk_sync_delay: assert property (
        rise_ev[0] |-> $past(capture_input_a, 2) && $past(capture_input_a, 3))
        else $error("edge seen before pin settled");

    chk_cap_store: assert property (
        s_store_rise_a |=> cap_val[0].rise == $past(slice[0]) && cap_irq[0])
        else $error("rising capture not stored");

    chk_gang_high: assert property (
        s_gang_rise |=> cap_val[1].rise == $past(timer_reg[15:8])
            && cap_val[0].rise == $past(timer_reg[7:0]))
        else $error("ganged capture wrong");

    chk_gang_irq: assert property (
        cap_irq[1] |-> !$past(cap_cfg.gang))
        else $error("channel 1 interrupt while ganged");

endmodule

// File: sim/frtc_pin_drv.sv
`timescale 1ns/1ps
// external source for the two capture pins
module frtc_pin_drv (
    // clock
    input wire logic mclk,
    // pins
    output logic pin_a,
    output logic pin_b
);
    initial begin
        pin_a = 1'b0;
        pin_b = 1'b0;
    end
    // levels change just after an edge, never mid-cycle
    task automatic drive(input logic ch, input logic lvl);
        @(posedge mclk);
        if (ch) begin
            pin_b <= lvl;
        end else begin
            pin_a <= lvl;
        end
    endtask
endmodule

// File: sim/test_frtc_timer_capture.sv
`timescale 1ns/1ps
`include "frtc_consts.svh"
module test_frtc_timer_capture import frtc_pkg::*;;
    logic mclk = 1'b0, rst = 1'b1, pin_a, pin_b, intv_en = 1'b0;
    frtc_cfg_s cap_cfg = '0;
    logic [15:0] intv_period = 16'h0003, timer_count, t;
    frtc_cap_s [1:0] cap_val;
    logic intv_irq, ms_tick_irq, wrap_irq;
    logic [1:0] cap_irq;
    int err_total = 0, tests_run = 0, cyc = 0, n;
    frtc_pin_drv frtc_pin_drv_i (.mclk(mclk), .pin_a(pin_a), .pin_b(pin_b));
    frtc_timer_capture frtc_timer_capture_i (.mclk(mclk), .rst(rst),
        .capture_input_a(pin_a), .capture_input_b(pin_b),
        .cap_cfg(cap_cfg), .intv_en(intv_en), .intv_period(intv_period),
        .timer_count(timer_count), .cap_val(cap_val), .intv_irq(intv_irq),
        .ms_tick_irq(ms_tick_irq), .wrap_irq(wrap_irq), .cap_irq(cap_irq));
    initial begin
        forever #5 mclk = ~mclk;
    end
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            err_total++;
            $display("ERROR %0t: got %h want %h", $time, seen, exp);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    // pin moves just after a timer step so the slice cannot shift meanwhile
    task automatic cap_edge(input int ch, input logic lvl, input logic want);
        logic [15:0] t0;
        t0 = timer_count;
        for (n = 0; n < 200 && timer_count === t0; n++) begin
            @(posedge mclk);
            #1;
        end
        frtc_pin_drv_i.drive(ch[0], lvl);
        t = timer_count;
        for (n = 0; n < 8 && cap_irq[ch] !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk({15'h0, cap_irq[ch]}, {15'h0, want});
    endtask
    // counts edges between two timer steps, independent of entry phase
    task automatic t_timer();
        cap_edge(0, 1'b0, 1'b0);
        t = timer_count;
        for (n = 0; n < 200 && timer_count === t; n++) begin
            @(posedge mclk);
            #1;
        end
        t = timer_count;
        for (n = 0; n < 200 && timer_count === t; n++) begin
            @(posedge mclk);
            #1;
        end
        chk(n[15:0], 16'(`FRTC_US_CYCLES));
        chk(timer_count, t + 16'h0001);
        $display("timer step done");
    endtask
    task automatic t_intv();
        @(posedge mclk);
        intv_en <= 1'b1;
        for (n = 0; n < 1000 && intv_irq !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        @(posedge mclk);
        #1;
        chk({15'h0, intv_irq}, 16'h0000);
        for (n = 1; n < 1000 && intv_irq !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk(n[15:0], intv_period * 16'(`FRTC_US_CYCLES));
        @(posedge mclk);
        intv_en <= 1'b0;
        $display("interval done");
    endtask
    // runs before the captures so every captured byte is nonzero
    task automatic t_ms();
        for (n = 0; n < 110000 && ms_tick_irq !== 1'b1; n++) begin
            @(posedge mclk);
            #1;
        end
        chk(timer_count, 16'(`FRTC_MS_TICK_US));
        chk({15'h0, wrap_irq}, 16'h0000);
        @(posedge mclk);
        #1;
        chk({15'h0, ms_tick_irq}, 16'h0000);
        $display("tick done");
    endtask
    task automatic t_cap();
        @(posedge mclk);
        cap_cfg <= '{rise_en: 2'b11, fall_en: 2'b01, gang: 1'b0,
            slice_lsb: {4'h9, 4'h4}};
        cap_edge(0, 1'b1, 1'b1);
        chk({8'h00, cap_val[0].rise}, {8'h00, t[11:4]});
        cap_edge(0, 1'b0, 1'b1);
        chk({8'h00, cap_val[0].fall}, {8'h00, t[11:4]});
        cap_edge(1, 1'b1, 1'b1);
        chk({8'h00, cap_val[1].rise}, {8'h00, t[15:8]});
        cap_edge(1, 1'b0, 1'b0);
        chk({8'h00, cap_val[1].fall}, 16'h0000);
        $display("capture done");
    endtask
    task automatic t_gang();
        @(posedge mclk);
        cap_cfg.gang <= 1'b1;
        cap_edge(0, 1'b1, 1'b1);
        chk({cap_val[1].rise, cap_val[0].rise}, t);
        cap_edge(1, 1'b1, 1'b0);
        cap_edge(0, 1'b0, 1'b1);
        chk({cap_val[1].fall, cap_val[0].fall}, t);
        $display("gang done");
    endtask
    always @(posedge mclk) begin
        cyc++;
        if (cyc == 120000) begin
            err_total++;
            close_out();
        end
    end
    initial begin
        repeat (8) @(posedge mclk);
        rst <= 1'b0;
        t_timer();
        t_intv();
        t_ms();
        t_cap();
        t_gang();
        close_out();
    end
endmodule
